// >>> rtl/flash_op_sequencer_status.sv
// flash operation sequencer with host handshake and mailbox status
`timescale 1ns/1ps
`default_nettype none
module flash_op_sequencer_status (
  input  wire logic        clk,
  input  wire logic        resetn,
  // external host side
  input  wire logic        hostMode,
  input  wire logic        progStrobeN,
  input  wire logic [7:0]  hostCmd,
  input  wire logic [15:0] hostAddr,
  input  wire logic [7:0]  hostData,
  input  wire logic        hostVerify,
  output logic             readyBusy,
  output logic [7:0]       hostDataOut,
  // mailbox side
  input  wire logic        cmdWrite,
  input  wire logic [7:0]  cmdByte,
  input  wire logic [7:0]  addrHigh,
  input  wire logic [7:0]  addrLow,
  input  wire logic [7:0]  dataIn,
  input  wire logic [7:0]  configByte,
  output logic [7:0]       statusByte,
  output logic [7:0]       dataMailbox,
  output logic             extIrqOne,
  // code read port
  input  wire logic        codeReadReq,
  input  wire logic        codeReadBlk,
  output logic             codeReadFail,
  // flash array and option side
  input  wire logic [7:0]  arrayRdData,
  output logic             arrayWrite,
  output logic [1:0]       eraseKind,
  output logic             eraseBlk,
  output logic [15:0]      arrayAddr,
  output logic [7:0]       arrayWrData,
  output logic [2:0]       securityBits,
  output logic [1:0]       storedMapDefault,
  output logic [1:0]       activeMap,
  output logic             oscRun
);
  // ==========================================================
  // reset synchroniser
  logic [1:0] rstSync_ff;
  logic       rstN;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstSync_ff <= 2'b00;
    end else begin
      rstSync_ff <= {rstSync_ff[0], 1'b1};
    end
  end
  assign rstN = rstSync_ff[1];

  // ==========================================================
  // state
  typedef struct packed {
    fosq_pkg::fosq_state_type st;
    logic [7:0]  cmd;
    logic [15:0] addr;
    logic [7:0]  data;
    logic [15:0] timer;
    logic        fromHost;
    logic        burst;
    logic        pending;
    logic        isErase;
    logic        readyBusy;
    logic [7:0]  hostOut;
    logic [7:0]  status;
    logic [7:0]  mailbox;
    logic        irq;
    logic        readFail;
    logic        wr;
    logic [1:0]  eraseKind;
    logic        eraseBlk;
    logic [2:0]  sec;
    logic [1:0]  mapDef;
    logic [1:0]  activeMap;
    logic        mapLoaded;
    logic        strobeLast;
    logic        osc;
  } fosq_regs_type;

  fosq_regs_type r_ff;
  fosq_regs_type nxt_r;
  logic          tick;

  fosq_timebase u_tb (
    .clk  (clk),
    .rstN (rstN),
    .run  (r_ff.st != fosq_pkg::FOSQ_IDLE),
    .tick (tick)
  );

  // ==========================================================
  // decode helpers
  function automatic logic blkOf(input logic [15:0] a);
    blkOf = (a[15:12] == fosq_pkg::BLK1_TAG);
  endfunction

  function automatic logic sameRow(input logic [15:0] a, input logic [15:0] b);
    if (blkOf(a)) begin
      sameRow = (a >> fosq_pkg::ROW_SHIFT_S) == (b >> fosq_pkg::ROW_SHIFT_S);
    end else begin
      sameRow = (a >> fosq_pkg::ROW_SHIFT_P) == (b >> fosq_pkg::ROW_SHIFT_P);
    end
  endfunction

  function automatic logic [15:0] durOf(input logic [7:0] c, input logic brst);
    unique case (c[6:0])
      fosq_pkg::CMD_CHIP[6:0]:   durOf = 16'(fosq_pkg::CHIP_US);
      fosq_pkg::CMD_BLOCK[6:0]:  durOf = 16'(fosq_pkg::BLOCK_US);
      fosq_pkg::CMD_SECTOR[6:0]: durOf = 16'(fosq_pkg::SECTOR_US);
      fosq_pkg::CMD_BURST[6:0]:  durOf = brst ? 16'(fosq_pkg::BURST_US) : 16'(fosq_pkg::BYTE_US);
      fosq_pkg::CMD_VERIFY[6:0]: durOf = fosq_pkg::TIME_ZERO;
      default:                   durOf = 16'(fosq_pkg::BYTE_US);
    endcase
  endfunction

  function automatic logic isEraseCmd(input logic [7:0] c);
    isEraseCmd = (c[6:0] == fosq_pkg::CMD_CHIP[6:0]) || (c[6:0] == fosq_pkg::CMD_BLOCK[6:0])
              || (c[6:0] == fosq_pkg::CMD_SECTOR[6:0]);
  endfunction

  // locked when any lock bit guards the addressed block; bit 0 guards all
  function automatic logic lockedFor(input logic [2:0] s, input logic [15:0] a);
    lockedFor = s[0] | (blkOf(a) ? s[2] : s[1]);
  endfunction

  // ==========================================================
  // next state
  logic        hostFall;
  logic        mbStart;
  logic [7:0]  newCmd;
  logic [15:0] newAddr;
  logic [7:0]  newData;
  logic        newHost;
  logic        startReq;

  always_comb begin
    nxt_r = r_ff;
    nxt_r.wr = 1'b0;
    nxt_r.strobeLast = progStrobeN;
    hostFall = hostMode && r_ff.strobeLast && !progStrobeN;
    mbStart  = !hostMode && cmdWrite && configByte[fosq_pkg::CFG_EN_BIT];
    newHost  = hostFall;
    newCmd   = hostFall ? hostCmd : cmdByte;
    newAddr  = hostFall ? hostAddr : {addrHigh, addrLow};
    newData  = hostFall ? hostData : dataIn;
    startReq = (hostFall || mbStart)
            && (newCmd[6:0] == fosq_pkg::CMD_CHIP[6:0] || !lockedFor(r_ff.sec, newAddr));
    if (!r_ff.mapLoaded) begin
      nxt_r.activeMap = r_ff.mapDef;
      nxt_r.mapLoaded = 1'b1;
    end
    nxt_r.readFail = codeReadReq && r_ff.st != fosq_pkg::FOSQ_IDLE
                  && (r_ff.burst || blkOf(r_ff.addr) == codeReadBlk);
    unique case (r_ff.st)
      fosq_pkg::FOSQ_IDLE: begin
        nxt_r.readyBusy = 1'b1;
        nxt_r.status[fosq_pkg::ST_BUSY_BIT] = 1'b0;
        if (startReq) begin
          nxt_r.cmd = newCmd;
          nxt_r.addr = newAddr;
          nxt_r.data = newData;
          nxt_r.fromHost = newHost;
          nxt_r.isErase = isEraseCmd(newCmd);
          nxt_r.burst = 1'b0;
          nxt_r.pending = 1'b0;
          nxt_r.timer = durOf(newCmd, 1'b0);
          nxt_r.readyBusy = 1'b0;
          nxt_r.status[fosq_pkg::ST_BUSY_BIT] = 1'b1;
          nxt_r.status[fosq_pkg::ST_BYTE_BIT] = 1'b1;
          nxt_r.irq = 1'b0;
          nxt_r.st = fosq_pkg::FOSQ_RUN;
        end
      end
      fosq_pkg::FOSQ_RUN: begin
        if (tick && r_ff.timer != fosq_pkg::TIME_ZERO) begin
          nxt_r.timer = r_ff.timer - 16'h0001;
        end
        if (r_ff.timer == fosq_pkg::TIME_ZERO) begin
          nxt_r.st = fosq_pkg::FOSQ_DONE;
        end
      end
      fosq_pkg::FOSQ_DONE: begin
        // option bits live outside the array, so their commands never strobe it
        nxt_r.wr = 1'b1;
        nxt_r.eraseKind = 2'b00;
        nxt_r.eraseBlk = blkOf(r_ff.addr);
        unique case (r_ff.cmd[6:0])
          fosq_pkg::CMD_CHIP[6:0]: begin
            nxt_r.eraseKind = 2'b11;
            nxt_r.sec = 3'b000;
            nxt_r.mapDef = 2'b00;
          end
          fosq_pkg::CMD_BLOCK[6:0]:  nxt_r.eraseKind = 2'b10;
          fosq_pkg::CMD_SECTOR[6:0]: nxt_r.eraseKind = 2'b01;
          fosq_pkg::CMD_SB1[6:0]: begin
            nxt_r.wr = 1'b0;
            nxt_r.sec[0] = 1'b1;
          end
          fosq_pkg::CMD_SB2[6:0]: begin
            nxt_r.wr = 1'b0;
            nxt_r.sec[1] = 1'b1;
          end
          fosq_pkg::CMD_SB3[6:0]: begin
            nxt_r.wr = 1'b0;
            nxt_r.sec[2] = 1'b1;
          end
          fosq_pkg::CMD_RB0[6:0]: begin
            nxt_r.wr = 1'b0;
            nxt_r.mapDef[0] = 1'b1;
          end
          fosq_pkg::CMD_RB1[6:0]: begin
            nxt_r.wr = 1'b0;
            nxt_r.mapDef[1] = 1'b1;
          end
          fosq_pkg::CMD_VERIFY[6:0]: begin
            nxt_r.wr = 1'b0;
            nxt_r.mailbox = arrayRdData;
          end
          default: ;
        endcase
        if (r_ff.cmd[6:0] == fosq_pkg::CMD_BURST[6:0]) begin
          nxt_r.burst = 1'b1;
          nxt_r.readyBusy = 1'b1;
          nxt_r.status[fosq_pkg::ST_BYTE_BIT] = 1'b0;
          nxt_r.timer = 16'(fosq_pkg::TIMEOUT_US);
          nxt_r.st = fosq_pkg::FOSQ_WAIT;
        end else begin
          nxt_r.st = fosq_pkg::FOSQ_HOLD;
        end
      end
      fosq_pkg::FOSQ_WAIT: begin
        if (tick && r_ff.timer != fosq_pkg::TIME_ZERO) begin
          nxt_r.timer = r_ff.timer - 16'h0001;
        end
        if (hostFall || mbStart) begin
          if (newCmd[6:0] == fosq_pkg::CMD_BURST[6:0] && sameRow(newAddr, r_ff.addr)) begin
            nxt_r.addr = newAddr;
            nxt_r.data = newData;
            nxt_r.readyBusy = 1'b0;
            nxt_r.status[fosq_pkg::ST_BYTE_BIT] = 1'b1;
            nxt_r.cmd = newCmd;
            nxt_r.timer = durOf(newCmd, 1'b1);
            nxt_r.st = fosq_pkg::FOSQ_RUN;
            if (r_ff.timer == fosq_pkg::TIME_ZERO) begin
              nxt_r.timer = durOf(newCmd, 1'b0);
            end
          end else begin
            nxt_r.st = fosq_pkg::FOSQ_HOLD;
          end
        end else if (r_ff.timer == fosq_pkg::TIME_ZERO) begin
          nxt_r.st = fosq_pkg::FOSQ_HOLD;
        end
        nxt_r.readFail = codeReadReq;
      end
      fosq_pkg::FOSQ_HOLD: begin
        nxt_r.burst = 1'b0;
        nxt_r.readyBusy = 1'b1;
        nxt_r.status[fosq_pkg::ST_BUSY_BIT] = 1'b0;
        nxt_r.status[fosq_pkg::ST_BYTE_BIT] = 1'b1;
        nxt_r.irq = r_ff.cmd[fosq_pkg::CMD_IRQ_BIT] && !r_ff.fromHost;
        nxt_r.st = fosq_pkg::FOSQ_IDLE;
      end
      default: nxt_r.st = fosq_pkg::FOSQ_IDLE;
    endcase
    if (r_ff.irq) begin
      nxt_r.irq = 1'b0;
    end
    // data polling view for the host
    nxt_r.hostOut = arrayRdData;
    if (hostVerify && r_ff.st != fosq_pkg::FOSQ_IDLE) begin
      nxt_r.hostOut = 8'h00;
      if (!r_ff.isErase) begin
        nxt_r.hostOut[fosq_pkg::DP_HI_BIT] = ~r_ff.data[fosq_pkg::DP_HI_BIT];
        nxt_r.hostOut[fosq_pkg::DP_LO_BIT] = ~r_ff.data[fosq_pkg::DP_LO_BIT];
        if (r_ff.st == fosq_pkg::FOSQ_WAIT) begin
          nxt_r.hostOut[fosq_pkg::DP_HI_BIT] = r_ff.data[fosq_pkg::DP_HI_BIT];
        end
      end
    end
    // registered so the pin comes straight from a flop
    nxt_r.osc = nxt_r.st != fosq_pkg::FOSQ_IDLE;
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      r_ff <= '{st: fosq_pkg::FOSQ_IDLE, readyBusy: 1'b1, strobeLast: 1'b1, default: '0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign readyBusy        = r_ff.readyBusy;
  assign hostDataOut      = r_ff.hostOut;
  assign statusByte       = r_ff.status;
  assign dataMailbox      = r_ff.mailbox;
  assign extIrqOne        = r_ff.irq;
  assign codeReadFail     = r_ff.readFail;
  assign arrayWrite       = r_ff.wr;
  assign eraseKind        = r_ff.eraseKind;
  assign eraseBlk         = r_ff.eraseBlk;
  assign arrayAddr        = r_ff.addr;
  assign arrayWrData      = r_ff.data;
  assign securityBits     = r_ff.sec;
  assign storedMapDefault = r_ff.mapDef;
  assign activeMap        = r_ff.activeMap;
  assign oscRun           = r_ff.osc;
endmodule
`default_nettype wire

// >>> pkg/fosq_pkg.sv
// constants and types for the flash operation sequencer
// ==========================================================
// Contract
// - ready/busy pin drops after strobe falls, rises when operation completes.
// - ready/busy pin rises between burst bytes to accept the next byte.
// - late burst byte is held until next programming cycle.
// - busy program verify returns complemented bits 7 and 3; zero for erase.
// - busy program verify reflects last loaded byte, not the address.
// - true bit 7 after each burst byte; true bit 3 after burst end.
// - burst ends on new row, new strobed command, or time-out.
// - chip erase clears both blocks, lock bits and map default bits.
// - block erase picks primary if A15 is 0, secondary if A15..A12 all one.
// - sector erase clears 128-byte primary or 64-byte secondary sector.
// - self-programming commands except chip erase refused on locked block.
// - self-programming commands ignored until config bit 6 is set.
// - command register write starts operation using mailbox address and data.
// - burst codes 06h polled, 86h interrupt; other commands invalid during burst.
// - security bit commands only set bits, take effect on completion.
// - map default commands change stored bits only, not active mapping.
// - status bit 2 busy during operation, clears when ready; the code keeps it set while ready/busy is high between burst bytes.
// - status bit 3 drops between burst bytes to request next byte.
// - successful verify puts read byte in data mailbox.
// - code read to a busy block fails.
// - timing oscillator runs only during an operation.
// - command bit 7 raises internal interrupt request at completion.
package fosq_pkg;
  localparam int CLK_MHZ = 100;
  localparam int TICK_DIV = 100;                     // 1 us time base
  localparam int TIMEOUT_US = 20;
  localparam int BYTE_US = 110;
  localparam int BURST_US = 45;
  localparam int SECTOR_US = 1100;
  localparam int BLOCK_US = 9400;
  localparam int CHIP_US = 11700;
  localparam int DIV_CYCLES = CLK_MHZ * 1000 / (TICK_DIV * 10);
  localparam logic [7:0] CMD_CHIP = 8'h01;
  localparam logic [7:0] CMD_BLOCK = 8'h0D;
  localparam logic [7:0] CMD_SECTOR = 8'h0B;
  localparam logic [7:0] CMD_BYTE = 8'h0E;
  localparam logic [7:0] CMD_BURST = 8'h06;
  localparam logic [7:0] CMD_VERIFY = 8'h0C;
  localparam logic [7:0] CMD_SB1 = 8'h0F;
  localparam logic [7:0] CMD_SB2 = 8'h03;
  localparam logic [7:0] CMD_SB3 = 8'h05;
  localparam logic [7:0] CMD_RB0 = 8'h08;
  localparam logic [7:0] CMD_RB1 = 8'h09;
  localparam int CMD_IRQ_BIT = 7;
  localparam int CFG_EN_BIT = 6;
  localparam int ST_BUSY_BIT = 2;
  localparam int ST_BYTE_BIT = 3;
  localparam int DP_HI_BIT = 7;
  localparam int DP_LO_BIT = 3;
  localparam logic [3:0] BLK1_TAG = 4'hF;
  localparam int ROW_SHIFT_P = 6;                    // half of 128-byte sector
  localparam int ROW_SHIFT_S = 5;                    // half of 64-byte sector
  localparam logic [7:0] ERASED = 8'h00;
  localparam logic [15:0] TIME_ZERO = 16'h0000;
  typedef enum logic [4:0] {
    FOSQ_IDLE  = 5'b0_0001,
    FOSQ_RUN   = 5'b0_0010,
    FOSQ_WAIT  = 5'b0_0100,
    FOSQ_DONE  = 5'b0_1000,
    FOSQ_HOLD  = 5'b1_0000
  } fosq_state_type;
endpackage

// >>> rtl/fosq_timebase.sv
// one microsecond tick divider, running only when enabled
`timescale 1ns/1ps
`default_nettype none
module fosq_timebase (
  input  wire logic clk,
  input  wire logic rstN,
  input  wire logic run,
  output logic      tick
);
  logic [7:0] cnt_ff;
  // ==========================================================
  // divider
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cnt_ff <= 8'h00;
      tick   <= 1'b0;
    end else if (!run) begin
      cnt_ff <= 8'h00;
      tick   <= 1'b0;
    end else if (cnt_ff == 8'(fosq_pkg::DIV_CYCLES - 1)) begin
      cnt_ff <= 8'h00;
      tick   <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
      tick   <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> sim/fosq_checker_asserts.sv
// port-level assertion checker for the flash operation sequencer
`timescale 1ns/1ps
`default_nettype none
module fosq_checker_asserts (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       hostMode,
  input wire logic       hostVerify,
  input wire logic       readyBusy,
  input wire logic [7:0] hostDataOut,
  input wire logic       cmdWrite,
  input wire logic [7:0] cmdByte,
  input wire logic [7:0] configByte,
  input wire logic [7:0] statusByte,
  input wire logic       extIrqOne,
  input wire logic       codeReadReq,
  input wire logic       codeReadFail,
  input wire logic [2:0] securityBits,
  input wire logic [1:0] storedMapDefault,
  input wire logic [1:0] activeMap,
  input wire logic       oscRun
);
  // ==========================================================
  // helper: cycles since reset, saturating
  logic [3:0] upCnt_ff;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      upCnt_ff <= 4'h0;
    end else if (upCnt_ff != 4'hF) begin
      upCnt_ff <= upCnt_ff + 4'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // properties
  property p_busy_rb; !readyBusy |-> statusByte[2]; endproperty
  property p_start;
    !hostMode && cmdWrite && configByte[6] && (cmdByte[6:0] == 7'h0E) && readyBusy && !statusByte[2]
      && (securityBits == 3'b000) |-> ##[1:2] statusByte[2];
  endproperty
  property p_ignore;
    !hostMode && cmdWrite && !configByte[6] && readyBusy && !statusByte[2] |=> !statusByte[2] [*4];
  endproperty
  property p_irq; extIrqOne |=> !extIrqOne; endproperty
  property p_osc; (!hostMode && !statusByte[2]) [*4] |-> !oscRun; endproperty
  property p_poll;
    hostMode && hostVerify && !readyBusy ##1 !readyBusy |-> (hostDataOut & 8'h77) == 8'h00;
  endproperty
  property p_code; codeReadFail |-> $past(codeReadReq) && $past(statusByte[2] || !readyBusy); endproperty
  property p_map; upCnt_ff == 4'hF |-> $stable(activeMap); endproperty
  property p_map_hold; $changed(storedMapDefault) |=> $stable(activeMap); endproperty
  a_busy_rb: assert property (p_busy_rb) else $error("ready low without busy status");
  a_start: assert property (p_start) else $error("enabled command did not start");
  a_ignore: assert property (p_ignore) else $error("command taken while disabled");
  a_irq: assert property (p_irq) else $error("completion request longer than one cycle");
  a_osc: assert property (p_osc) else $error("oscillator runs while idle");
  a_poll: assert property (p_poll) else $error("busy verify shows extra bits");
  a_code: assert property (p_code) else $error("code read failed while idle");
  a_map: assert property (p_map) else $error("active map changed after reset");
  a_map_hold: assert property (p_map_hold) else $error("active map followed stored default");
  c_irq: cover property (extIrqOne);
  c_wait: cover property (readyBusy && statusByte[2]);
  c_fail: cover property (codeReadFail);
  c_poll: cover property (hostMode && hostVerify && readyBusy && statusByte[2]);
endmodule
bind flash_op_sequencer_status fosq_checker_asserts CHK (.*);
`default_nettype wire

// >>> sim/fosq_flash_model.sv
// flash array model answering the sequencer's array port
`timescale 1ns/1ps
`default_nettype none
module fosq_flash_model (
  input  wire logic        clk,
  input  wire logic        arrayWrite,
  input  wire logic [1:0]  eraseKind,
  input  wire logic [15:0] arrayAddr,
  input  wire logic [7:0]  arrayWrData,
  output logic [7:0]       arrayRdData
);
  // ==========================================================
  // store: low address byte only, the bench uses few places
  logic [7:0] mem [256];
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
  end
  // programming can only clear bits, so it ands into the cell
  always @(posedge clk) begin
    if (arrayWrite === 1'b1 && eraseKind === 2'b00) begin
      mem[arrayAddr[7:0]] <= mem[arrayAddr[7:0]] & arrayWrData;
    end else if (arrayWrite === 1'b1) begin
      foreach (mem[i]) mem[i] <= 8'hFF;
    end
  end
  assign arrayRdData = mem[arrayAddr[7:0]];
endmodule
`default_nettype wire

// >>> sim/flash_op_sequencer_status_tb.sv
// self-checking bench for the flash operation sequencer
`timescale 1ns/1ps
`default_nettype none
module flash_op_sequencer_status_tb;
  typedef struct packed {
    logic [7:0] cfg; logic [7:0] cmd; logic [15:0] addr; logic [7:0] data;
    logic [1:0] busy; logic [2:0] sec; logic [1:0] map; logic [7:0] mb;
  } fosq_row_type;
  logic        clk = 1'b0, resetn = 1'b0, hostMode = 1'b0, progStrobeN = 1'b1, hostVerify = 1'b0;
  logic        cmdWrite = 1'b0, codeReadReq = 1'b0, codeReadBlk = 1'b0;
  logic [7:0]  hostCmd = 8'h00, hostData = 8'h00, cmdByte = 8'h00, addrHigh = 8'h00;
  logic [7:0]  addrLow = 8'h00, dataIn = 8'h00, configByte = 8'h00;
  logic [15:0] hostAddr = 16'h0000;
  logic        readyBusy, extIrqOne, codeReadFail, arrayWrite, eraseBlk, oscRun;
  logic [7:0]  hostDataOut, statusByte, dataMailbox, arrayRdData, arrayWrData;
  logic [1:0]  eraseKind, storedMapDefault, activeMap;
  logic [2:0]  securityBits;
  logic [15:0] arrayAddr, wrAddr;
  logic [7:0]  wrData;
  int          n_mismatch = 0, compares = 0, irqCnt = 0;
  fosq_row_type rows [7];
  fosq_row_type r;
  flash_op_sequencer_status DUT (.*);
  fosq_flash_model PART (.*);
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (arrayWrite === 1'b1 && eraseKind === 2'b00) begin
      wrAddr <= arrayAddr;
      wrData <= arrayWrData;
    end
    if (extIrqOne === 1'b1) irqCnt <= irqCnt + 1;
  end
  // ==========================================================
  // tasks
  task automatic finish_test();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one-cycle command pulse; mailbox levels stay put afterwards
  task automatic mbox(input logic [7:0] cfg, input logic [7:0] cmd, input logic [15:0] a, input logic [7:0] d);
    configByte = cfg;
    cmdByte = cmd;
    {addrHigh, addrLow} = a;
    dataIn = d;
    cmdWrite = 1'b1;
    @(negedge clk);
    cmdWrite = 1'b0;
  endtask
  task automatic wait_idle(input int n);
    int i;
    for (i = 0; i < n; i++) begin
      if (statusByte[2] === 1'b0 && readyBusy === 1'b1) break;
      @(negedge clk);
    end
    if (i == n) begin
      n_mismatch++;
      finish_test();
    end
    repeat (4) @(negedge clk);
  endtask
  task automatic wait_rb(input int n);
    int i;
    for (i = 0; i < n && readyBusy !== 1'b1; i++) @(negedge clk);
    if (i == n) begin
      n_mismatch++;
      finish_test();
    end
  endtask
  task automatic do_reset(input int n);
    resetn = 1'b0;
    repeat (n) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    chk("readyBusy", 16'h0001, readyBusy);
    chk("statusByte", 16'h0000, statusByte);
    chk("oscRun", 16'h0000, oscRun);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    rows[0] = '{8'h00, fosq_pkg::CMD_BYTE, 16'h0010, 8'hA5, 2'd0, 3'b000, 2'b00, 8'h00};
    rows[1] = '{8'h40, fosq_pkg::CMD_RB0, 16'h0000, 8'h00, 2'd1, 3'b000, 2'b01, 8'h00};
    rows[2] = '{8'h40, fosq_pkg::CMD_BYTE | 8'h80, 16'h0010, 8'hA5, 2'd1, 3'b000, 2'b01, 8'h00};
    rows[3] = '{8'h40, fosq_pkg::CMD_VERIFY, 16'h0010, 8'h00, 2'd2, 3'b000, 2'b01, 8'hA5};
    rows[4] = '{8'h40, fosq_pkg::CMD_SB2, 16'h0000, 8'h00, 2'd1, 3'b010, 2'b01, 8'hA5};
    rows[5] = '{8'h40, fosq_pkg::CMD_BYTE, 16'h0020, 8'h11, 2'd0, 3'b010, 2'b01, 8'hA5};
    rows[6] = '{8'h40, fosq_pkg::CMD_BLOCK, 16'h0000, 8'h00, 2'd0, 3'b010, 2'b01, 8'hA5};
    do_reset(12);
    foreach (rows[i]) begin
      r = rows[i];
      mbox(r.cfg, r.cmd, r.addr, r.data);
      @(negedge clk);
      if (r.busy != 2'd2) chk("busy", r.busy[0], statusByte[2]);
      wait_idle(12000);
      chk("securityBits", r.sec, securityBits);
      chk("storedMapDefault", r.map, storedMapDefault);
      chk("activeMap", 16'h0000, activeMap);
      chk("dataMailbox", r.mb, dataMailbox);
      if ((r.cmd & 8'h7F) == fosq_pkg::CMD_BYTE && r.busy == 2'd1) begin
        chk("wrAddr", r.addr, wrAddr);
        chk("wrData", r.data, wrData);
      end
    end
    chk("irqCnt", 16'h0001, irqCnt[15:0]);
    // host strobe path with polling and a code read into the busy block
    hostMode = 1'b1;
    @(negedge clk);
    hostCmd = fosq_pkg::CMD_BYTE;
    hostAddr = 16'hF010;
    hostData = 8'h5A;
    progStrobeN = 1'b0;
    repeat (3) @(negedge clk);
    chk("readyBusy", 16'h0000, readyBusy);
    progStrobeN = 1'b1;
    hostAddr = 16'hF0FF;
    hostVerify = 1'b1;
    repeat (2) @(negedge clk);
    chk("hostDataOut", 16'h0080, hostDataOut);
    hostVerify = 1'b0;
    codeReadBlk = 1'b1;
    codeReadReq = 1'b1;
    @(negedge clk);
    codeReadReq = 1'b0;
    chk("codeReadFail", 16'h0001, codeReadFail);
    wait_idle(12000);
    hostMode = 1'b0;
    repeat (4) @(negedge clk);
    chk("oscRun", 16'h0000, oscRun);
    chk("wrAddr", 16'hF010, wrAddr);
    chk("eraseBlk", 16'h0001, eraseBlk);
    chk("eraseKind", 16'h0000, eraseKind);
    // burst: one byte, then let the inter-byte wait run out
    mbox(8'h40, fosq_pkg::CMD_BURST, 16'hF020, 8'h3C);
    @(negedge clk);
    wait_rb(12000);
    chk("burstWait", 16'h0004, {8'h00, statusByte & 8'h0C});
    wait_idle(3000);
    chk("wrData", 16'h003C, wrData);
    // host burst: second byte in time, then a new row ends it at once
    hostMode = 1'b1;
    hostCmd = fosq_pkg::CMD_BURST;
    hostAddr = 16'hF040;
    hostData = 8'hC3;
    @(negedge clk);
    progStrobeN = 1'b0;
    @(negedge clk);
    progStrobeN = 1'b1;
    wait_rb(12000);
    hostVerify = 1'b1;
    @(negedge clk);
    chk("burstPoll", 16'h0088, hostDataOut);
    hostVerify = 1'b0;
    hostAddr = 16'hF041;
    hostData = 8'h96;
    progStrobeN = 1'b0;
    @(negedge clk);
    progStrobeN = 1'b1;
    chk("readyBusy", 16'h0000, readyBusy);
    wait_rb(5000);
    hostAddr = 16'hF080;
    progStrobeN = 1'b0;
    @(negedge clk);
    progStrobeN = 1'b1;
    wait_idle(100);
    chk("wrAddr", 16'hF041, wrAddr);
    chk("wrData", 16'h0096, wrData);
    hostMode = 1'b0;
    do_reset(3);
    finish_test();
  end
endmodule
`default_nettype wire
